/* smi_pkg.sv */
// Shared constants and types for the SIMD multiply, interpolate and LZD datapath
package smi_pkg;

  localparam int NCH = 16;
  localparam int DW  = 32;

  // Operation codes
  localparam logic [7:0] OP_MAC  = 8'h48;
  localparam logic [7:0] OP_MACH = 8'h49;
  localparam logic [7:0] OP_LZD  = 8'h4A;
  localparam logic [7:0] OP_LINE = 8'h59;
  localparam logic [7:0] OP_MAD  = 8'h5B;
  localparam logic [7:0] OP_LRP  = 8'h5C;

  // Region and width constants
  localparam logic [3:0] THREE_SRC_VSTRIDE = 4'h4;
  localparam logic [4:0] WIDTH_8           = 5'h08;
  localparam logic [4:0] WIDTH_16          = 5'h10;
  localparam logic [2:0] SUBREG_LOW        = 3'h0;
  localparam logic [2:0] SUBREG_HIGH       = 3'h4;
  localparam logic [1:0] FOURTH_SLOT       = 2'h3;

  // Arithmetic constants
  localparam logic [31:0] HIGH_WORD_MASK = 32'hFFFF0000;
  localparam logic [31:0] FP_ONE         = 32'h3F800000;
  localparam logic [5:0]  LZD_ALL_ZERO   = 6'h20;
  localparam int          FP_BIAS        = 127;
  localparam logic [7:0]  FP_EXP_MAX     = 8'hFF;

  typedef enum logic [1:0] {
    SMI_T_UD = 2'b00,
    SMI_T_D  = 2'b01,
    SMI_T_F  = 2'b10
  } smi_type_e;

  typedef logic [NCH-1:0][DW-1:0] smi_lanes_t;
  typedef logic [7:0][DW-1:0]     smi_group_t;

endpackage : smi_pkg

/* smi_if.sv */
// Issue link between operand fetch and the SIMD datapath
`timescale 1ns/1ps
interface smi_if;
  logic                       issue_valid;
  logic [7:0]                 opcode;
  smi_pkg::smi_type_e         dtype;
  logic                       accumulator_write_option;
  logic                       acc_load;
  logic [smi_pkg::NCH-1:0]    channel_write_enable;
  logic [4:0]                 execution_width;
  logic [3:0]                 vertical_region_stride;
  logic [2:0]                 src_abs;
  smi_pkg::smi_lanes_t        src0;
  smi_pkg::smi_lanes_t        src1;
  smi_pkg::smi_lanes_t        src2;
  smi_pkg::smi_group_t        scalar_group;
  logic [2:0]                 scalar_subreg;
  logic                       res_valid;
  logic                       res_illegal;
  logic [smi_pkg::NCH-1:0]    res_mask;
  smi_pkg::smi_lanes_t        res_data;
  logic [3:0]                 region_vstride;

  modport device (
    input  issue_valid, opcode, dtype, accumulator_write_option, acc_load,
           channel_write_enable, execution_width, vertical_region_stride,
           src_abs, src0, src1, src2, scalar_group, scalar_subreg,
    output res_valid, res_illegal, res_mask, res_data, region_vstride
  );

  modport issuer (
    output issue_valid, opcode, dtype, accumulator_write_option, acc_load,
           channel_write_enable, execution_width, vertical_region_stride,
           src_abs, src0, src1, src2, scalar_group, scalar_subreg,
    input  res_valid, res_illegal, res_mask, res_data, region_vstride
  );
endinterface : smi_if

/* smi_datapath.sv */
// Device end: per-channel SIMD arithmetic with 64-bit channel accumulators
`timescale 1ns/1ps
module smi_datapath #(
  parameter int NCH = smi_pkg::NCH
) (
  input  wire logic clock,
  input  wire logic srst,
  smi_if.device     link
);

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers (single precision, denormals flushed, truncating)
  function automatic logic [31:0] fmul(input logic [31:0] a,
                                       input logic [31:0] b);
    logic        s;
    logic [47:0] m;
    int          e;
    s = a[31] ^ b[31];
    m = {1'b1, a[22:0]} * {1'b1, b[22:0]};
    e = int'(a[30:23]) + int'(b[30:23]) - smi_pkg::FP_BIAS;
    if (m[47]) begin
      m = m >> 1;
      e = e + 1;
    end
    if (a[30:23] == 8'h00 || b[30:23] == 8'h00 || e <= 0)
      return {s, 31'h0};
    if (e >= int'(smi_pkg::FP_EXP_MAX))
      return {s, smi_pkg::FP_EXP_MAX, 23'h0};
    return {s, e[7:0], m[45:23]};
  endfunction : fmul

  function automatic logic [31:0] fadd(input logic [31:0] a,
                                       input logic [31:0] b);
    logic [31:0] x;
    logic [31:0] y;
    logic [26:0] mx;
    logic [26:0] my;
    logic [27:0] sum;
    int          ex;
    int          sh;
    x = a;
    y = b;
    if (a[30:0] < b[30:0]) begin
      x = b;
      y = a;
    end
    ex = int'(x[30:23]);
    sh = ex - int'(y[30:23]);
    if (ex == 0)
      return 32'h0;
    mx = {1'b1, x[22:0], 3'h0};
    my = (y[30:23] == 8'h00) ? 27'h0 : {1'b1, y[22:0], 3'h0};
    my = (sh > 26) ? 27'h0 : (my >> sh);
    if (x[31] == y[31])
      sum = {1'b0, mx} + {1'b0, my};
    else
      sum = {1'b0, mx} - {1'b0, my};
    if (sum == 28'h0)
      return 32'h0;
    if (sum[27]) begin
      sum = sum >> 1;
      ex  = ex + 1;
    end
    for (int k = 0; k < 27; k++) begin
      if (!sum[26]) begin
        sum = sum << 1;
        ex  = ex - 1;
      end
    end
    if (ex <= 0)
      return {x[31], 31'h0};
    if (ex >= int'(smi_pkg::FP_EXP_MAX))
      return {x[31], smi_pkg::FP_EXP_MAX, 23'h0};
    return {x[31], ex[7:0], sum[25:3]};
  endfunction : fadd

  function automatic logic [5:0] lzc(input logic [31:0] v);
    logic [5:0] c;
    c = smi_pkg::LZD_ALL_ZERO;
    for (int k = 0; k < 32; k++) begin
      if (v[k])
        c = 6'(31 - k);
    end
    return c;
  endfunction : lzc

  // Signed or unsigned 32x32 product, 64-bit result
  function automatic logic [63:0] imul(input logic [31:0] a,
                                       input logic [31:0] b,
                                       input logic        sgn);
    logic signed [32:0] xa;
    logic signed [32:0] xb;
    logic signed [65:0] p;
    xa = {sgn & a[31], a};
    xb = {sgn & b[31], b};
    p  = xa * xb;
    return p[63:0];
  endfunction : imul

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic [63:0]         acc_reg [NCH];
  smi_pkg::smi_lanes_t dst_reg;
  logic [NCH-1:0]      mask_reg;
  logic                valid_reg;
  logic                illegal_reg;
  logic [3:0]          vstride_reg;

  wire is_line  = link.opcode == smi_pkg::OP_LINE;
  wire is_lrp   = link.opcode == smi_pkg::OP_LRP;
  wire is_lzd   = link.opcode == smi_pkg::OP_LZD;
  wire is_mac   = link.opcode == smi_pkg::OP_MAC;
  wire is_mach  = link.opcode == smi_pkg::OP_MACH;
  wire is_mad   = link.opcode == smi_pkg::OP_MAD;
  wire known_op = is_line | is_lrp | is_lzd | is_mac | is_mach | is_mad;
  wire three_src = is_lrp | is_mad;
  wire is_float  = link.dtype == smi_pkg::SMI_T_F;
  wire is_signed = link.dtype == smi_pkg::SMI_T_D;
  // Zero count never touches the accumulator; high MAC always does
  wire acc_upd   = is_mach
                 | (link.accumulator_write_option & ~is_lzd);

  wire [3:0] vstride_next = three_src ? smi_pkg::THREE_SRC_VSTRIDE
                                      : link.vertical_region_stride;

  // Line scalars: slope at the selected dword, offset in the last dword of its four-dword half (slot 3 or 7)
  wire [31:0] line_p = link.scalar_group[link.scalar_subreg];
  wire [31:0] line_q =
    link.scalar_group[{link.scalar_subreg[2], smi_pkg::FOURTH_SLOT}];

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel lanes
  logic [31:0] lane_res [NCH];
  logic [63:0] lane_acc [NCH];
  logic [NCH-1:0] lane_en;

  for (genvar i = 0; i < NCH; i++) begin : g_lane
    wire        sg  = is_signed;
    wire [31:0] s0r = link.src0[i];
    wire [31:0] s1r = link.src1[i];
    wire [31:0] s2r = link.src2[i];
    // Abs modifier; the issuer keeps it on sources 0 and 1 only when signed or of D/F type, always on source 2
    wire [31:0] a0 = !link.src_abs[0] ? s0r : is_float ? {1'b0, s0r[30:0]}
                   : s0r[31] ? 32'(-s0r) : s0r;
    wire [31:0] a1 = !link.src_abs[1] ? s1r : is_float ? {1'b0, s1r[30:0]}
                   : s1r[31] ? 32'(-s1r) : s1r;
    wire [31:0] a2 = !link.src_abs[2] ? s2r : is_float ? {1'b0, s2r[30:0]}
                   : s2r[31] ? 32'(-s2r) : s2r;
    wire [31:0] acc_lo = acc_reg[i][31:0];
    wire [63:0] mac_i  = acc_reg[i] + imul(a0, a1, sg);
    wire [63:0] mach_i = acc_reg[i]
                       + imul(a0 & smi_pkg::HIGH_WORD_MASK, a1, sg);
    wire [63:0] mad_i  = imul(a1, a2, sg) + {{32{sg & a0[31]}}, a0};

    assign lane_en[i] = link.channel_write_enable[i]
                        && (i < int'(link.execution_width));

    always_comb begin
      lane_res[i] = 32'h0;
      lane_acc[i] = acc_reg[i];
      if (is_line) begin
        lane_res[i] = fadd(fmul(line_p, a1), line_q);
      end else if (is_lrp) begin
        lane_res[i] = fadd(fmul(a1, a0),
                           fmul(a2, fadd(smi_pkg::FP_ONE,
                                         {~a0[31], a0[30:0]})));
      end else if (is_lzd) begin
        lane_res[i] = {26'h0, lzc(a0)};
      end else if (is_mac) begin
        lane_res[i] = is_float ? fadd(fmul(a0, a1), acc_lo)
                               : mac_i[31:0];
      end else if (is_mach) begin
        lane_res[i] = mach_i[63:32];
      end else if (is_mad) begin
        lane_res[i] = is_float ? fadd(fmul(a1, a2), a0) : mad_i[31:0];
      end
      if (is_mach)
        lane_acc[i] = mach_i;
      else if (is_mac && !is_float)
        lane_acc[i] = mac_i;
      else
        lane_acc[i] = {{32{sg & lane_res[i][31]}}, lane_res[i]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result and accumulator registers
  always_ff @(posedge clock) begin
    if (srst) begin
      valid_reg   <= 1'b0;
      illegal_reg <= 1'b0;
      mask_reg    <= '0;
      dst_reg     <= '0;
      vstride_reg <= 4'h0;
    end else begin
      valid_reg   <= link.issue_valid;
      illegal_reg <= link.issue_valid & ~link.acc_load & ~known_op;
      if (link.issue_valid) begin
        vstride_reg <= vstride_next;
        mask_reg    <= (known_op && !link.acc_load) ? lane_en : '0;
      end
      for (int i = 0; i < NCH; i++) begin
        if (link.issue_valid && !link.acc_load && known_op && lane_en[i])
          dst_reg[i] <= lane_res[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < NCH; i++) begin
      if (srst)
        acc_reg[i] <= 64'h0;
      else if (link.issue_valid && lane_en[i]) begin
        if (link.acc_load)
          acc_reg[i] <= {link.src1[i], link.src0[i]};
        else if (known_op && acc_upd)
          acc_reg[i] <= lane_acc[i];
      end
    end
  end

  assign link.res_valid      = valid_reg;
  assign link.res_illegal    = illegal_reg;
  assign link.res_mask       = mask_reg;
  assign link.res_data       = dst_reg;
  assign link.region_vstride = vstride_reg;

endmodule : smi_datapath

/* smi_issuer.sv */
// Issuer end: checks operand legality and drives requests onto the link
`timescale 1ns/1ps
module smi_issuer #(
  parameter int NCH = smi_pkg::NCH
) (
  input  wire logic                clock,
  input  wire logic                srst,
  smi_if.issuer                    link,
  input  wire logic                req_valid,
  input  wire logic [7:0]          req_opcode,
  input  wire smi_pkg::smi_type_e  req_dtype,
  input  wire logic [1:0]          req_src_signed,
  input  wire logic                req_acc_write,
  input  wire logic                req_acc_load,
  input  wire logic                req_acc_explicit,
  input  wire logic                req_cmod_overflow,
  input  wire logic                req_saturate,
  input  wire logic [NCH-1:0]      req_mask,
  input  wire logic [4:0]          req_width,
  input  wire logic [3:0]          req_hstride,
  input  wire logic [3:0]          req_vstride,
  input  wire logic [2:0]          req_abs,
  input  wire smi_pkg::smi_lanes_t req_src0,
  input  wire smi_pkg::smi_lanes_t req_src1,
  input  wire smi_pkg::smi_lanes_t req_src2,
  input  wire smi_pkg::smi_group_t req_group,
  input  wire logic [2:0]          req_subreg,
  output logic                     req_refused,
  output logic                     res_valid,
  output logic                     res_illegal,
  output logic [NCH-1:0]           res_mask,
  output smi_pkg::smi_lanes_t      res_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Legality checks
  wire op_line = req_opcode == smi_pkg::OP_LINE;
  wire op_lrp  = req_opcode == smi_pkg::OP_LRP;
  wire op_lzd  = req_opcode == smi_pkg::OP_LZD;
  wire op_mach = req_opcode == smi_pkg::OP_MACH;
  wire dst_d   = req_dtype == smi_pkg::SMI_T_D;
  wire full    = req_mask == {NCH{1'b1}};

  wire bad_line = op_line && !((req_width == smi_pkg::WIDTH_8
                  || req_width == smi_pkg::WIDTH_16)
                  && req_hstride == 4'h0 && req_vstride == 4'h0
                  && (req_subreg == smi_pkg::SUBREG_LOW
                  || req_subreg == smi_pkg::SUBREG_HIGH));
  wire bad_lrp  = op_lrp && req_cmod_overflow;
  wire bad_lzd  = op_lzd && (req_dtype != smi_pkg::SMI_T_UD
                  || (req_src_signed[0] && !req_abs[0]));
  wire bad_mach = op_mach && (!full || req_saturate
                  || (dst_d && req_src_signed != 2'b11)
                  || (!dst_d && |(req_src_signed & ~req_abs[1:0]))
                  || !(dst_d || req_dtype == smi_pkg::SMI_T_UD));
  wire bad_acc  = req_acc_explicit;
  wire bad_load = req_acc_load && (!full || req_saturate);
  wire refuse   = req_valid && (req_acc_load ? bad_load
                  : (bad_line | bad_lrp | bad_lzd | bad_mach | bad_acc));
  wire accept   = req_valid && !refuse;
  // Abs is meaningless on unsigned sources, so it is dropped there on sources 0 and 1; source 2 keeps it
  wire [1:0] src_sgn = req_src_signed | {2{req_dtype != smi_pkg::SMI_T_UD}};
  wire [2:0] abs_eff = {req_abs[2], req_abs[1:0] & src_sgn};

  ////////////////////////////////////////////////////////////////////////////
  // Request registers
  logic                valid_reg;
  logic                refused_reg;
  logic [7:0]          opcode_reg;
  smi_pkg::smi_type_e  dtype_reg;
  logic                accw_reg;
  logic                load_reg;
  logic [NCH-1:0]      mask_reg;
  logic [4:0]          width_reg;
  logic [3:0]          vstride_reg;
  logic [2:0]          abs_reg;
  smi_pkg::smi_lanes_t src0_reg;
  smi_pkg::smi_lanes_t src1_reg;
  smi_pkg::smi_lanes_t src2_reg;
  smi_pkg::smi_group_t group_reg;
  logic [2:0]          subreg_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      valid_reg   <= 1'b0;
      refused_reg <= 1'b0;
      opcode_reg  <= 8'h00;
      dtype_reg   <= smi_pkg::SMI_T_UD;
      accw_reg    <= 1'b0;
      load_reg    <= 1'b0;
      mask_reg    <= '0;
      width_reg   <= 5'h00;
      vstride_reg <= 4'h0;
      abs_reg     <= 3'h0;
      src0_reg    <= '0;
      src1_reg    <= '0;
      src2_reg    <= '0;
      group_reg   <= '0;
      subreg_reg  <= 3'h0;
    end else begin
      valid_reg   <= accept;
      refused_reg <= refuse;
      if (accept) begin
        opcode_reg  <= req_opcode;
        dtype_reg   <= req_dtype;
        accw_reg    <= req_acc_write | op_mach;
        load_reg    <= req_acc_load;
        mask_reg    <= req_mask;
        width_reg   <= req_width;
        vstride_reg <= req_vstride;
        abs_reg     <= abs_eff;
        src0_reg    <= req_src0;
        src1_reg    <= req_src1;
        src2_reg    <= req_src2;
        group_reg   <= req_group;
        subreg_reg  <= req_subreg;
      end
    end
  end

  assign link.issue_valid              = valid_reg;
  assign link.opcode                   = opcode_reg;
  assign link.dtype                    = dtype_reg;
  assign link.accumulator_write_option = accw_reg;
  assign link.acc_load                 = load_reg;
  assign link.channel_write_enable     = mask_reg;
  assign link.execution_width          = width_reg;
  assign link.vertical_region_stride   = vstride_reg;
  assign link.src_abs                  = abs_reg;
  assign link.src0                     = src0_reg;
  assign link.src1                     = src1_reg;
  assign link.src2                     = src2_reg;
  assign link.scalar_group             = group_reg;
  assign link.scalar_subreg            = subreg_reg;

  assign req_refused = refused_reg;
  assign res_valid   = link.res_valid;
  assign res_illegal = link.res_illegal;
  assign res_mask    = link.res_mask;
  assign res_data    = link.res_data;

endmodule : smi_issuer

/* smi_if_asserts.sv */
// Concurrent checks on the issue link between issuer and datapath
`timescale 1ns/1ps
module smi_if_asserts (
  input wire logic                    clock,
  input wire logic                    srst,
  input wire logic                    issue_valid,
  input wire logic [7:0]              opcode,
  input wire smi_pkg::smi_type_e      dtype,
  input wire logic                    acc_load,
  input wire logic [smi_pkg::NCH-1:0] channel_write_enable,
  input wire logic [4:0]              execution_width,
  input wire smi_pkg::smi_lanes_t     src0,
  input wire smi_pkg::smi_lanes_t     src1,
  input wire smi_pkg::smi_lanes_t     src2,
  input wire logic                    res_valid,
  input wire logic                    res_illegal,
  input wire logic [smi_pkg::NCH-1:0] res_mask,
  input wire smi_pkg::smi_lanes_t     res_data,
  input wire logic [3:0]              region_vstride
);
  wire [smi_pkg::NCH-1:0] lane_on;
  wire known_op = opcode inside {smi_pkg::OP_MAC, smi_pkg::OP_MACH,
    smi_pkg::OP_LZD, smi_pkg::OP_LINE, smi_pkg::OP_MAD, smi_pkg::OP_LRP};
  wire [31:0]  mad_next = src1[0] * src2[0] + src0[0];
  logic [31:0] mad_reg;

  for (genvar k = 0; k < smi_pkg::NCH; k++) begin : g_lane
    assign lane_on[k] = channel_write_enable[k] && (k < execution_width);
  end

  // Lane 0 multiply-add result expected one cycle after the request
  always_ff @(posedge clock) begin
    mad_reg <= mad_next;
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_take;
    issue_valid && !acc_load && known_op;
  endsequence
  sequence s_three_src;
    issue_valid && !acc_load &&
      (opcode == smi_pkg::OP_LRP || opcode == smi_pkg::OP_MAD);
  endsequence
  sequence s_mad_lane0;
    s_take ##0 (opcode == smi_pkg::OP_MAD && dtype != smi_pkg::SMI_T_F
      && lane_on[0]);
  endsequence

  chk_result_one_cycle: assert property (issue_valid |=> res_valid)
    else $error("result missing one cycle after request");
  chk_no_stray_result: assert property (!issue_valid |=> !res_valid)
    else $error("result without request");
  chk_vstride_forced: assert property (
    s_three_src |=> region_vstride == smi_pkg::THREE_SRC_VSTRIDE)
    else $error("three-source stride not forced");
  chk_mask_follows_enable: assert property (
    s_take |=> res_mask == $past(lane_on) && !res_illegal)
    else $error("written lanes differ from enabled lanes");
  chk_unknown_op_idle: assert property (
    issue_valid && !acc_load && !known_op |=> res_illegal && res_mask == '0)
    else $error("unknown opcode not flagged");
  chk_load_no_write: assert property (
    issue_valid && acc_load |=> res_mask == '0 && !res_illegal)
    else $error("accumulator load wrote lanes");
  chk_lzd_zero_count: assert property (
    s_take ##0 (opcode == smi_pkg::OP_LZD && lane_on[0] && src0[0] == '0)
    |=> res_data[0] == 32'h00000020)
    else $error("zero source count wrong");
  chk_mad_lane_zero: assert property (s_mad_lane0 |=>
    res_data[0] == mad_reg)
    else $error("multiply-add lane 0 wrong");
  chk_idle_lane_keeps: assert property (
    s_take ##0 !lane_on[1] |=> $stable(res_data[1]))
    else $error("disabled lane changed");
endmodule : smi_if_asserts

/* smi_tb_top.sv */
// Bench driving the issuer into the datapath with a lane model
`timescale 1ns/1ps
module smi_tb_top;
  logic                    clock = 1'b0;
  logic                    srst = 1'b1;
  logic                    req_valid = 1'b0;
  logic [7:0]              req_opcode = 8'h00;
  smi_pkg::smi_type_e      req_dtype = smi_pkg::SMI_T_UD;
  logic [1:0]              req_src_signed = 2'h0;
  logic                    req_acc_write = 1'b0;
  logic                    req_acc_load = 1'b0;
  logic                    req_acc_explicit = 1'b0;
  logic                    req_cmod_overflow = 1'b0;
  logic                    req_saturate = 1'b0;
  logic [smi_pkg::NCH-1:0] req_mask = '0;
  logic [4:0]              req_width = 5'h10;
  logic [3:0]              req_hstride = 4'h0;
  logic [3:0]              req_vstride = 4'h0;
  logic [2:0]              req_abs = 3'h0;
  smi_pkg::smi_lanes_t     req_src0 = '0;
  smi_pkg::smi_lanes_t     req_src1 = '0;
  smi_pkg::smi_lanes_t     req_src2 = '0;
  smi_pkg::smi_group_t     req_group = '0;
  logic [2:0]              req_subreg = 3'h0;
  logic                    req_refused;
  logic                    res_valid;
  logic                    res_illegal;
  logic [smi_pkg::NCH-1:0] res_mask;
  smi_pkg::smi_lanes_t     res_data;
  int                      err_count = 0;
  int                      checked = 0;
  int                      cycles = 0;
  logic [63:0]             mdl_acc [smi_pkg::NCH];
  logic [31:0]             mdl_dst [smi_pkg::NCH];
  logic [smi_pkg::NCH-1:0] mdl_mask_q [$];
  logic [31:0]             fexp = 32'h00000000;

  smi_if link ();
  smi_datapath smi_datapath_i (.clock(clock), .srst(srst), .link(link));
  smi_issuer smi_issuer_i (.link(link), .*);
  smi_if_asserts smi_if_asserts_i (.clock(clock), .srst(srst),
    .issue_valid(link.issue_valid), .opcode(link.opcode),
    .dtype(link.dtype), .acc_load(link.acc_load),
    .channel_write_enable(link.channel_write_enable),
    .execution_width(link.execution_width), .src0(link.src0),
    .src1(link.src1), .src2(link.src2), .res_valid(link.res_valid),
    .res_illegal(link.res_illegal), .res_mask(link.res_mask),
    .res_data(link.res_data), .region_vstride(link.region_vstride));

  always #20 clock = ~clock;

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      err_count++;
      conclude();
    end
  end

  function automatic logic [63:0] calc(input int k);
    logic [63:0] a;
    logic [31:0] v;
    a = mdl_acc[k];
    case (req_opcode)
      smi_pkg::OP_MAC: return a + 64'(req_src0[k]) * 64'(req_src1[k]);
      smi_pkg::OP_MACH: return a + 64'(req_src1[k]) *
        64'(req_src0[k] & smi_pkg::HIGH_WORD_MASK);
      smi_pkg::OP_MAD: return req_dtype == smi_pkg::SMI_T_F ? 64'(fexp)
        : 64'(req_src1[k] * req_src2[k] + req_src0[k]);
      smi_pkg::OP_LZD: begin
        v = req_src0[k];
        if (req_src_signed[0] && req_abs[0] && v[31]) v = -v;
        for (int b = 31; b >= 0; b--) begin
          if (v[b]) return 64'(31 - b);
        end
        return 64'h20;
      end
      default: return 64'(fexp);
    endcase
  endfunction : calc

  task automatic setup(input logic [7:0] op, input logic [31:0] keep);
    req_opcode <= op;
    req_acc_write <= 1'b0;
    req_acc_load <= 1'b0;
    req_acc_explicit <= 1'b0;
    req_cmod_overflow <= 1'b0;
    req_src_signed <= 2'h0;
    req_abs <= 3'h0;
    req_dtype <= smi_pkg::SMI_T_UD;
    req_mask <= '1;
    req_width <= 5'h10;
    req_vstride <= op == smi_pkg::OP_LINE ? 4'h0 : 4'($urandom);
    req_subreg <= 3'h0;
    for (int k = 0; k < smi_pkg::NCH; k++) begin
      req_src0[k] <= $urandom & keep;
      req_src1[k] <= $urandom & keep;
      req_src2[k] <= $urandom & keep;
    end
  endtask : setup

  task automatic send(input string name, input bit refuse);
    logic [63:0]             sum;
    logic [smi_pkg::NCH-1:0] m;
    bit                      known;
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    m = '0;
    known = !req_acc_load && req_opcode inside {smi_pkg::OP_MAC,
      smi_pkg::OP_MACH, smi_pkg::OP_LZD, smi_pkg::OP_LINE,
      smi_pkg::OP_MAD, smi_pkg::OP_LRP};
    for (int k = 0; k < smi_pkg::NCH && !refuse; k++) begin
      sum = calc(k);
      if (req_acc_load) mdl_acc[k] = {req_src1[k], req_src0[k]};
      if (known && req_mask[k] && k < req_width) begin
        m[k] = 1'b1;
        mdl_dst[k] = req_opcode == smi_pkg::OP_MACH ? sum[63:32] : sum[31:0];
        if (req_opcode == smi_pkg::OP_MACH ||
            (req_acc_write && req_opcode != smi_pkg::OP_LZD)) begin
          mdl_acc[k] = sum;
        end
      end
    end
    if (!refuse) mdl_mask_q.push_back(m);
    #1;
    check("refused", req_refused, refuse);
    @(posedge clock);
    #1;
    check("valid", res_valid, !refuse);
    if (!refuse) begin
      check("illegal", res_illegal, !known && !req_acc_load);
      check("mask", res_mask, mdl_mask_q.pop_front());
      for (int k = 0; k < smi_pkg::NCH; k++) begin
        check("lane", res_data[k], mdl_dst[k]);
      end
    end
    $display("test %s done", name);
  endtask : send

  //////////////////////////////////////////////////////////////////////////
  initial begin
    for (int k = 0; k < smi_pkg::NCH; k++) begin
      mdl_acc[k] = 64'h0;
      mdl_dst[k] = 32'h0;
    end
    void'($urandom(43));
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
    check("idle", res_valid, 1'b0);
    @(posedge clock);
    setup(smi_pkg::OP_MAC, 32'hFFFFFFFF);
    req_acc_load <= 1'b1;
    send("seed", 1'b0);
    repeat (2) begin
      @(posedge clock);
      setup(smi_pkg::OP_MACH, 32'hFFFFFFFF);
      req_acc_write <= 1'b1;
      send("mach", 1'b0);
    end
    for (int c = 0; c < 3; c++) begin
      @(posedge clock);
      setup(c == 1 ? smi_pkg::OP_MAD : smi_pkg::OP_MAC, 32'h0000FFFF);
      req_acc_write <= 1'b1;
      req_mask <= 16'($urandom) | 16'h0001;
      req_width <= c == 1 ? 5'h08 : 5'h10;
      send("mac mad", 1'b0);
    end
    @(posedge clock);
    setup(smi_pkg::OP_LZD, 32'h0);
    req_mask <= 16'($urandom) | 16'h8001;
    req_src_signed <= 2'h1;
    req_abs <= 3'h1;
    req_src0[15] <= 32'hFFFFFFFC;
    for (int k = 1; k < smi_pkg::NCH - 1; k++) begin
      req_src0[k] <= (32'h80000000 >> (2 * k - 1)) | ($urandom >> (2 * k));
    end
    send("lzd", 1'b0);
    for (int s = 0; s < 8; s += 4) begin
      @(posedge clock);
      setup(smi_pkg::OP_LINE, 32'h0);
      req_subreg <= 3'(s);
      req_width <= s == 0 ? 5'h10 : 5'h08;
      req_mask <= 16'($urandom);
      fexp = 32'h40E00000;
      for (int d = 0; d < 8; d++) begin
        req_group[d] <= d == s ? 32'h40000000 :
          d == (s | 3) ? 32'h3F800000 : $urandom;
      end
      for (int k = 0; k < smi_pkg::NCH; k++) begin
        req_src1[k] <= 32'h40400000;
      end
      send("line", 1'b0);
    end
    @(posedge clock);
    setup(smi_pkg::OP_LRP, 32'h0);
    req_mask <= 16'($urandom);
    fexp = 32'h40400000;
    for (int k = 0; k < smi_pkg::NCH; k++) begin
      req_src0[k] <= 32'h3F000000;
      req_src1[k] <= 32'h40800000;
      req_src2[k] <= 32'h40000000;
    end
    send("lrp", 1'b0);
    @(posedge clock);
    setup(smi_pkg::OP_MAD, 32'h0);
    req_dtype <= smi_pkg::SMI_T_F;
    fexp = 32'h40E00000;
    for (int k = 0; k < smi_pkg::NCH; k++) begin
      req_src0[k] <= 32'h3F800000;
      req_src1[k] <= 32'h40000000;
      req_src2[k] <= 32'h40400000;
    end
    send("fmad", 1'b0);
    @(posedge clock);
    setup(8'h00, 32'hFFFFFFFF);
    send("unknown", 1'b0);
    for (int c = 0; c < 6; c++) begin
      @(posedge clock);
      setup(c == 0 ? smi_pkg::OP_LRP : c == 1 ? smi_pkg::OP_LINE :
        c == 2 ? smi_pkg::OP_LZD : smi_pkg::OP_MACH, 32'h0);
      case (c)
        0: req_cmod_overflow <= 1'b1;
        1: req_width <= 5'h0C;
        2: req_src_signed <= 2'h1;
        3: req_mask <= 16'h7FFF;
        4: req_src_signed <= 2'h2;
        default: req_acc_explicit <= 1'b1;
      endcase
      send("refusal", 1'b1);
    end
    conclude();
  end
endmodule : smi_tb_top
